/* File: hdl/sfv_defines.svh */
// Constants for the servo follow and velocity mode block
// Operation
// - Register gearing: code 223, two words, register 10..199
// - Slave change equals master change times ratio
// - Packed register: master upper half, slave lower
// - Negative packed slave change reverses slave direction
// - Master signal double low-pass for velocity feedforward
// - Direct gearing: code 180, two words, +-32767
// - Unity scale 1024, 512, 256 per resolution
// - Negative direct scale factor reverses motor
// - Torque input: code 218, four words, register 12
// - Velocity input: code 217, four words, same parameters
// - Program velocity: code 159, seven words, ramp
// - Run until stop input, ramp down, end
// - Busy while executing: answer busy refusal (code refuses only program velocity)
// - Multitasking: take over motion, zero velocity ends
// - External input select: code 192, four words
`ifndef SFV_DEFINES_SVH
`define SFV_DEFINES_SVH

`define SFV_CODE_REG_GEAR   8'hdf
`define SFV_CODE_DIR_GEAR   8'hb4
`define SFV_CODE_TORQ_IN    8'hda
`define SFV_CODE_VEL_IN     8'hd9
`define SFV_CODE_PROG_VEL   8'h9f
`define SFV_CODE_EXT_IN     8'hc0
`define SFV_WORDS_GEAR      3'h2
`define SFV_WORDS_INPUT     3'h4
`define SFV_WORDS_PROG_VEL  3'h7
`define SFV_REG_MIN         16'h000a
`define SFV_REG_MAX         16'h00c7
`define SFV_IN_REG          8'h0c
`define SFV_SF_ILLEGAL      16'h8000
`define SFV_ACC_MAX         32'h3fffffff
`define SFV_UNITY_4K        17'h00400
`define SFV_UNITY_8K        17'h00200
`define SFV_UNITY_16K       17'h00100
`define SFV_FILT_ONE        17'h08000
`define SFV_STYLE_STEP_DIR  4'h2
`define SFV_OFF_CMD         12'h000
`define SFV_OFF_RESP        12'h004
`define SFV_OFF_CTRL        12'h008
`define SFV_OFF_FILT        12'h00c
`define SFV_OFF_STAT        12'h010
`define SFV_OFF_EXT_IN      12'h014
`define SFV_MEM_SEL         2'h1
`define SFV_CTRL_MULTITASK  0
`define SFV_CTRL_PROG_RUN   1
`define SFV_RESP_ACK        8'h01
`define SFV_RESP_BUSY       8'h02
`define SFV_RESP_RANGE      8'h03
`define SFV_RESP_CODE       8'h04
`define SFV_AXI_OKAY        2'h0
`define SFV_AXI_SLVERR      2'h2
`define SFV_PERIOD_NS       120000
`define SFV_CLK_NS          50
`define SFV_PERIOD_CYC      ((`SFV_PERIOD_NS + `SFV_CLK_NS - 1) / `SFV_CLK_NS)

`endif

/* File: hdl/sfv_pkg.sv */
// Types of the servo follow and velocity mode block
`default_nettype none
package sfv_pkg;

  typedef enum logic [2:0] {
    MODE_IDLE,
    MODE_REG_GEAR,
    MODE_DIR_GEAR,
    MODE_TORQ_IN,
    MODE_VEL_IN,
    MODE_PROG_VEL
  } sfv_mode_type;

  typedef struct packed {
    logic               awready, wready, aw_got, w_got, bvalid;
    logic [1:0]         bresp;
    logic [11:0]        aw_addr;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               arready, rd_pend, rvalid;
    logic [1:0]         rresp;
    logic [11:0]        ar_addr;
    logic [31:0]        rdata;
    logic [6:0][15:0]   cmd_w;
    logic [2:0]         cmd_cnt;
    logic [7:0]         resp, resp_seq, ctrl;
    logic [31:0]        filt;
    sfv_mode_type       mode;
    logic [7:0]         gear_reg;
    logic signed [15:0] dir_sf;
    logic signed [47:0] gear_rem;
    logic [15:0]        in_k, stop_en, stop_st;
    logic [31:0]        acc;
    logic signed [31:0] vel_target, vel, in_filt, ff1, ff2, slave_delta;
    logic [3:0]         ext_style;
    logic               index_src;
    logic [15:0]        index_state;
    logic [11:0]        tick_cnt;
    logic               tick_p;
    logic signed [15:0] master_acc;
    logic [1:0]         ab_s1, ab_s2, ab_prev;
    logic [15:0]        io_s1, io_s2;
  } sfv_state_type;

endpackage
`default_nettype wire

/* File: hdl/sfv_user_mem.sv */
// User data register memory with two registered read ports
`default_nettype none
module sfv_user_mem #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          i_clk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [31:0]   i_wdata,
  input  wire logic [AW-1:0] i_raddr_a,
  input  wire logic [AW-1:0] i_raddr_b,
  output logic      [31:0]   o_rdata_a,
  output logic      [31:0]   o_rdata_b
);
  logic [31:0] mem [DEPTH];

  // Address width must reach every entry
  generate
    if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad
      $error("sfv_user_mem: DEPTH does not fit AW");
    end
  endgenerate

  // No reset on the array; contents are undefined until written
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata_a <= mem[i_raddr_a];
    o_rdata_b <= mem[i_raddr_b];
  end
endmodule
`default_nettype wire

/* File: hdl/sfv_follow.sv */
// Servo follow, input and program velocity modes behind AXI4-Lite
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`include "sfv_defines.svh"
`default_nettype none
module sfv_follow #(
  parameter int IO_W  = 8,
  parameter int DEPTH = 256
) (
  input  wire logic            i_clk,
  input  wire logic            i_reset_n,
  input  wire logic [11:0]     i_awaddr,
  input  wire logic            i_awvalid,
  output logic                 o_awready,
  input  wire logic [31:0]     i_wdata,
  input  wire logic [3:0]      i_wstrb,
  input  wire logic            i_wvalid,
  output logic                 o_wready,
  output logic      [1:0]      o_bresp,
  output logic                 o_bvalid,
  input  wire logic            i_bready,
  input  wire logic [11:0]     i_araddr,
  input  wire logic            i_arvalid,
  output logic                 o_arready,
  output logic      [31:0]     o_rdata,
  output logic      [1:0]      o_rresp,
  output logic                 o_rvalid,
  input  wire logic            i_rready,
  input  wire logic            i_enc_a,
  input  wire logic            i_enc_b,
  input  wire logic [IO_W-1:0] i_io,
  output logic      [2:0]      o_mode,
  output logic                 o_tick,
  output logic      [31:0]     o_slave_delta,
  output logic      [31:0]     o_vel_ff,
  output logic      [31:0]     o_vel_cmd,
  output logic      [31:0]     o_input_cmd,
  output logic      [3:0]      o_ext_style,
  output logic                 o_index_src,
  output logic      [15:0]     o_index_state
);
  localparam logic [15:0] IO_MASK = 16'((17'h1 << IO_W) - 17'h1);
  localparam logic [11:0] TICK_LAST = 12'(`SFV_PERIOD_CYC - 1);

  sfv_pkg::sfv_state_type st;
  sfv_pkg::sfv_state_type next_st;

  logic               aw_take, w_take, ar_take, wr_fire, wr_err;
  logic               exec_now, tick, busy, stop_hit, gear_packed;
  logic [6:0][15:0]   cw;
  logic [7:0]         code;
  logic [2:0]         need;
  logic [11:0]        rd_addr;
  logic [31:0]        rd_val, mem_rd_a, mem_rd_b;
  logic               mem_we;
  logic [7:0]         mem_raddr_a;
  logic [15:0]        stop_mask;
  logic signed [1:0]  inc;
  logic signed [16:0] den, unity;
  logic signed [31:0] factor, target, new_vel;
  logic signed [47:0] num, quot;
  logic signed [32:0] diff;

  // Parameter range the logic can serve
  generate
    if (IO_W < 1 || IO_W > 16 || DEPTH != 256) begin : g_bad
      $error("sfv_follow: IO_W must be 1..16 and DEPTH 256");
    end
  endgenerate

  // Words each command of the group occupies, code word included
  function automatic logic [2:0] words_of(input logic [7:0] c);
    case (c)
      `SFV_CODE_REG_GEAR, `SFV_CODE_DIR_GEAR: words_of = `SFV_WORDS_GEAR;
      `SFV_CODE_TORQ_IN, `SFV_CODE_VEL_IN,
      `SFV_CODE_EXT_IN:   words_of = `SFV_WORDS_INPUT;
      `SFV_CODE_PROG_VEL: words_of = `SFV_WORDS_PROG_VEL;
      default:            words_of = 3'h0;
    endcase
  endfunction

  // First order low-pass, k/32768 pole, used for all smoothing
  function automatic logic signed [31:0] lowpass(
    input logic signed [31:0] y,
    input logic signed [31:0] x,
    input logic [14:0]        k
  );
    logic signed [49:0] a;
    a = 50'(y * $signed({2'b00, k}))
      + 50'(x * $signed(`SFV_FILT_ONE - {2'b00, k}));
    return a[46:15];
  endfunction

  sfv_user_mem #(
    .DEPTH (DEPTH),
    .AW    (8)
  ) u_mem (
    .i_clk     (i_clk),
    .i_we      (mem_we),
    .i_waddr   (st.aw_addr[9:2]),
    .i_wdata   (st.w_data),
    .i_raddr_a (mem_raddr_a),
    .i_raddr_b (st.gear_reg),
    .o_rdata_a (mem_rd_a),
    .o_rdata_b (mem_rd_b)
  );

  // Next-state logic: bus slave, command assembly, control tick
  always_comb begin
    next_st = st;
    // Pins pass two flops before anything reads them
    next_st.ab_s1 = {i_enc_a, i_enc_b};
    next_st.ab_s2 = st.ab_s1;
    next_st.ab_prev = st.ab_s2;
    next_st.io_s1 = 16'(i_io);
    next_st.io_s2 = st.io_s1;

    // AXI write side: address and data taken in either order
    aw_take = i_awvalid && st.awready;
    w_take = i_wvalid && st.wready;
    if (aw_take) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = i_awaddr;
    end
    if (w_take) begin
      next_st.w_got = 1'b1;
      next_st.w_data = i_wdata;
      next_st.w_strb = i_wstrb;
    end
    wr_fire = st.aw_got && st.w_got && !st.bvalid;
    // Partial strobes refused: every register is one whole word
    wr_err = st.w_strb != 4'hf
      || !(st.aw_addr[11:10] == `SFV_MEM_SEL
      || st.aw_addr <= `SFV_OFF_EXT_IN);
    mem_we = wr_fire && !wr_err && st.aw_addr[11:10] == `SFV_MEM_SEL;
    if (wr_fire) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = wr_err ? `SFV_AXI_SLVERR : `SFV_AXI_OKAY;
      if (!wr_err && st.aw_addr == `SFV_OFF_CTRL) begin
        next_st.ctrl = st.w_data[7:0];
      end
      if (!wr_err && st.aw_addr == `SFV_OFF_FILT) begin
        next_st.filt = st.w_data;
      end
    end else if (st.bvalid && i_bready) begin
      next_st.bvalid = 1'b0;
    end
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready = !next_st.w_got && !next_st.bvalid;

    // AXI read side: one cycle for the memory's registered port
    ar_take = i_arvalid && st.arready;
    rd_addr = st.ar_addr;
    mem_raddr_a = ar_take ? i_araddr[9:2] : st.ar_addr[9:2];
    case (rd_addr)
      `SFV_OFF_CMD:    rd_val = {29'h0, st.cmd_cnt};
      `SFV_OFF_RESP:   rd_val = {16'h0, st.resp_seq, st.resp};
      `SFV_OFF_CTRL:   rd_val = {24'h0, st.ctrl};
      `SFV_OFF_FILT:   rd_val = st.filt;
      `SFV_OFF_STAT:   rd_val = {29'h0, st.mode};
      `SFV_OFF_EXT_IN: rd_val = {st.index_state, 11'h0, st.index_src,
                                 st.ext_style};
      default:         rd_val = mem_rd_a;
    endcase
    if (ar_take) begin
      next_st.arready = 1'b0;
      next_st.rd_pend = 1'b1;
      next_st.ar_addr = i_araddr;
    end
    if (st.rd_pend) begin
      next_st.rd_pend = 1'b0;
      next_st.rvalid = 1'b1;
      if (rd_addr[11:10] == `SFV_MEM_SEL || rd_addr <= `SFV_OFF_EXT_IN)
      begin
        next_st.rdata = rd_val;
        next_st.rresp = `SFV_AXI_OKAY;
      end else begin
        next_st.rdata = 32'h0;
        next_st.rresp = `SFV_AXI_SLVERR;
      end
    end else if (st.rvalid && i_rready) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end
    if (!st.arready && !st.rd_pend && !st.rvalid) begin
      next_st.arready = 1'b1;
    end

    // Master count from the selected encoder style
    inc = 2'sd0;
    if (st.ext_style == `SFV_STYLE_STEP_DIR) begin
      if (st.ab_s2[1] && !st.ab_prev[1]) begin
        inc = st.ab_s2[0] ? -2'sd1 : 2'sd1;
      end
    end else if ((st.ab_s2 ^ st.ab_prev) == 2'b01
      || (st.ab_s2 ^ st.ab_prev) == 2'b10) begin
      inc = (st.ab_prev[1] ^ st.ab_s2[0]) ? 2'sd1 : -2'sd1;
    end

    // Control period tick
    tick = st.tick_cnt == TICK_LAST;
    next_st.tick_cnt = tick ? 12'h0 : 12'(st.tick_cnt + 12'h1);
    next_st.tick_p = tick;
    next_st.master_acc = 16'(tick ? 16'(inc) : st.master_acc + 16'(inc));

    stop_mask = st.stop_en & IO_MASK;
    stop_hit = stop_mask != 16'h0
      && (st.io_s2 & stop_mask) == (st.stop_st & stop_mask);
    busy = st.ctrl[`SFV_CTRL_PROG_RUN]
      || st.mode != sfv_pkg::MODE_IDLE;

    // Gear ratio: scale form over unity, or packed slave/master pair
    case (st.ctrl[3:2])
      2'h1:    unity = `SFV_UNITY_8K;
      2'h2:    unity = `SFV_UNITY_16K;
      default: unity = `SFV_UNITY_4K;
    endcase
    gear_packed = st.mode == sfv_pkg::MODE_REG_GEAR
      && !mem_rd_b[31] && mem_rd_b[31:16] != 16'h0;
    if (gear_packed) begin
      factor = 32'(signed'(mem_rd_b[15:0]));
      den = signed'({2'b00, mem_rd_b[30:16]});
    end else if (st.mode == sfv_pkg::MODE_REG_GEAR) begin
      factor = signed'(mem_rd_b);
      den = unity;
    end else begin
      factor = 32'(st.dir_sf);
      den = unity;
    end
    // Remainder carried so no counts are lost between ticks
    num = st.gear_rem + 48'(st.master_acc * factor);
    quot = num / 48'(den);

    // Program velocity ramp toward target at the given rate
    target = stop_hit ? 32'sh0 : st.vel_target;
    diff = 33'(target) - 33'(st.vel);
    if (diff > 33'(signed'({1'b0, st.acc}))) begin
      new_vel = 32'(st.vel + signed'(st.acc));
    end else if (diff < -33'(signed'({1'b0, st.acc}))) begin
      new_vel = 32'(st.vel - signed'(st.acc));
    end else begin
      new_vel = target;
    end

    if (tick) begin
      // Feedforward filters follow the master in every mode
      next_st.ff1 = lowpass(st.ff1, {st.master_acc, 16'h0},
                            st.filt[30:16]);
      next_st.ff2 = lowpass(st.ff2, st.ff1, st.filt[14:0]);
      next_st.slave_delta = 32'sh0;
      case (st.mode)
        sfv_pkg::MODE_REG_GEAR, sfv_pkg::MODE_DIR_GEAR: begin
          next_st.slave_delta = quot[31:0];
          next_st.gear_rem = 48'(num - 48'(quot * 48'(den)));
        end
        sfv_pkg::MODE_TORQ_IN, sfv_pkg::MODE_VEL_IN: begin
          // Constant is the host's pole from the 120 us period
          next_st.in_filt = lowpass(st.in_filt, signed'(mem_rd_b),
                                    st.in_k[14:0]);
          if (stop_hit) begin
            next_st.mode = sfv_pkg::MODE_IDLE;
          end
        end
        sfv_pkg::MODE_PROG_VEL: begin
          next_st.vel = new_vel;
          next_st.vel_target = target;
          if (new_vel == 32'sh0 && target == 32'sh0) begin
            next_st.mode = sfv_pkg::MODE_IDLE;
          end
        end
        default: begin
        end
      endcase
    end

    // Command words arrive one per write of the command register
    cw = st.cmd_w;
    cw[st.cmd_cnt] = st.w_data[15:0];
    code = cw[0][7:0];
    need = words_of(code);
    exec_now = 1'b0;
    if (mem_we || !wr_fire || wr_err || st.aw_addr != `SFV_OFF_CMD) begin
      next_st.cmd_cnt = st.cmd_cnt;
    end else if (need == 3'h0) begin
      next_st.cmd_cnt = 3'h0;
      next_st.resp = `SFV_RESP_CODE;
      next_st.resp_seq = 8'(st.resp_seq + 8'h01);
    end else if (3'(st.cmd_cnt + 3'h1) == need) begin
      next_st.cmd_cnt = 3'h0;
      exec_now = 1'b1;
    end else begin
      next_st.cmd_w = cw;
      next_st.cmd_cnt = 3'(st.cmd_cnt + 3'h1);
    end

    // Mode switch only once the last parameter word is in
    if (exec_now) begin
      next_st.resp = `SFV_RESP_ACK;
      next_st.resp_seq = 8'(st.resp_seq + 8'h01);
      case (code)
        `SFV_CODE_REG_GEAR: begin
          if (cw[1] < `SFV_REG_MIN || cw[1] > `SFV_REG_MAX) begin
            next_st.resp = `SFV_RESP_RANGE;
          end else begin
            next_st.mode = sfv_pkg::MODE_REG_GEAR;
            next_st.gear_reg = cw[1][7:0];
            next_st.gear_rem = '0;
            next_st.vel = '0;
          end
        end
        `SFV_CODE_DIR_GEAR: begin
          // Inputs were set up earlier by the selection command
          if (cw[1] == `SFV_SF_ILLEGAL) begin
            next_st.resp = `SFV_RESP_RANGE;
          end else begin
            next_st.mode = sfv_pkg::MODE_DIR_GEAR;
            next_st.dir_sf = signed'(cw[1]);
            next_st.gear_rem = '0;
            next_st.vel = '0;
          end
        end
        `SFV_CODE_TORQ_IN, `SFV_CODE_VEL_IN: begin
          if (cw[1][15]) begin
            next_st.resp = `SFV_RESP_RANGE;
          end else begin
            next_st.mode = (code == `SFV_CODE_TORQ_IN)
              ? sfv_pkg::MODE_TORQ_IN : sfv_pkg::MODE_VEL_IN;
            next_st.gear_reg = `SFV_IN_REG;
            next_st.in_k = cw[1];
            next_st.stop_en = cw[2];
            next_st.stop_st = cw[3];
            next_st.in_filt = '0;
            next_st.vel = '0;
          end
        end
        `SFV_CODE_PROG_VEL: begin
          if ({cw[1], cw[2]} == 32'h0 || {cw[1], cw[2]} > `SFV_ACC_MAX)
          begin
            next_st.resp = `SFV_RESP_RANGE;
          end else if (busy && !st.ctrl[`SFV_CTRL_MULTITASK]) begin
            next_st.resp = `SFV_RESP_BUSY;
          end else begin
            // A new command in program velocity keeps the present speed; takeover from another mode starts the ramp at zero
            next_st.mode = sfv_pkg::MODE_PROG_VEL;
            next_st.acc = {cw[1], cw[2]};
            next_st.vel_target = signed'({cw[3], cw[4]});
            next_st.stop_en = cw[5];
            next_st.stop_st = cw[6];
            if (st.mode != sfv_pkg::MODE_PROG_VEL) begin
              next_st.vel = '0;
            end
          end
        end
        `SFV_CODE_EXT_IN: begin
          next_st.index_src = cw[1][0];
          next_st.index_state = cw[2];
          next_st.ext_style = cw[3][3:0];
        end
        default: begin
          next_st.resp = `SFV_RESP_CODE;
        end
      endcase
    end
  end

  // One register stage holds all state
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign o_awready = st.awready;
  assign o_wready = st.wready;
  assign o_bresp = st.bresp;
  assign o_bvalid = st.bvalid;
  assign o_arready = st.arready;
  assign o_rdata = st.rdata;
  assign o_rresp = st.rresp;
  assign o_rvalid = st.rvalid;
  assign o_mode = st.mode;
  assign o_tick = st.tick_p;
  assign o_slave_delta = st.slave_delta;
  assign o_vel_ff = st.ff2;
  assign o_vel_cmd = st.vel;
  assign o_input_cmd = st.in_filt;
  assign o_ext_style = st.ext_style;
  assign o_index_src = st.index_src;
  assign o_index_state = st.index_state;

  // Checks on the command, motion and bus write response behaviour
  a_ack_after_words: assert property (@(posedge i_clk)
    disable iff (!i_reset_n) exec_now |=> st.resp_seq ==
      8'($past(st.resp_seq) + 8'h01) && st.cmd_cnt == 3'h0)
    else $error("answer not given after last word");
  a_reg_range_low: assert property (@(posedge i_clk)
    disable iff (!i_reset_n) exec_now && code == `SFV_CODE_REG_GEAR
      && cw[1] < `SFV_REG_MIN |=> st.resp == `SFV_RESP_RANGE
      && $stable(st.mode))
    else $error("register number below range accepted");
  a_sf_illegal: assert property (@(posedge i_clk)
    disable iff (!i_reset_n) exec_now && code == `SFV_CODE_DIR_GEAR
      && cw[1] == `SFV_SF_ILLEGAL |=> st.resp == `SFV_RESP_RANGE)
    else $error("illegal direct scale factor accepted");
  a_busy_refuse: assert property (@(posedge i_clk)
    disable iff (!i_reset_n) exec_now && code == `SFV_CODE_PROG_VEL
      && busy && !st.ctrl[0] && {cw[1], cw[2]} != 32'h0
      && {cw[1], cw[2]} <= `SFV_ACC_MAX
      |=> st.resp == `SFV_RESP_BUSY && st.mode == $past(st.mode))
    else $error("program velocity not refused while busy");
  a_take_over: assert property (@(posedge i_clk)
    disable iff (!i_reset_n) exec_now && code == `SFV_CODE_PROG_VEL
      && st.ctrl[0] && {cw[1], cw[2]} != 32'h0
      && {cw[1], cw[2]} <= `SFV_ACC_MAX
      |=> st.mode == sfv_pkg::MODE_PROG_VEL
      && st.resp == `SFV_RESP_ACK)
    else $error("multitasking takeover failed");
  a_vel_end: assert property (@(posedge i_clk)
    disable iff (!i_reset_n) tick && !exec_now
      && st.mode == sfv_pkg::MODE_PROG_VEL && st.vel_target == 32'sh0
      && st.vel <= signed'(st.acc) && st.vel >= -signed'(st.acc)
      |=> st.mode == sfv_pkg::MODE_IDLE)
    else $error("velocity mode did not end at zero");
  a_vel_step: assert property (@(posedge i_clk)
    disable iff (!i_reset_n) tick && !exec_now
      && st.mode == sfv_pkg::MODE_PROG_VEL && !stop_hit
      && st.vel == 32'sh0 && st.vel_target > 32'sh0
      |=> st.vel == (st.vel_target < signed'(st.acc)
      ? st.vel_target : signed'(st.acc)))
    else $error("velocity ramp step wrong");
  a_ff_hold: assert property (@(posedge i_clk)
    disable iff (!i_reset_n) !tick |=> $stable(st.ff2) ##1 1'b1)
    else $error("feedforward moved off the tick");
  a_input_exit: assert property (@(posedge i_clk)
    disable iff (!i_reset_n) tick && !exec_now && stop_hit
      && st.mode == sfv_pkg::MODE_TORQ_IN
      |=> st.mode == sfv_pkg::MODE_IDLE)
    else $error("input mode ignored stop condition");
  a_bvalid_hold: assert property (@(posedge i_clk)
    disable iff (!i_reset_n) st.bvalid && !i_bready |=> st.bvalid)
    else $error("write response dropped before ready");
endmodule
`default_nettype wire

/* File: tb/sfv_host.sv */
// Host model sending command words over AXI4-Lite
`default_nettype none
module sfv_host (
  input  wire logic        i_clk,
  output logic      [11:0] o_awaddr = 12'h000,
  output logic             o_awvalid = 1'b0,
  input  wire logic        i_awready,
  output logic      [31:0] o_wdata = 32'h0,
  output logic             o_wvalid = 1'b0,
  input  wire logic        i_wready,
  input  wire logic        i_bvalid,
  output logic             o_bready = 1'b0,
  output logic      [11:0] o_araddr = 12'h000,
  output logic             o_arvalid = 1'b0,
  input  wire logic        i_arready,
  input  wire logic [31:0] i_rdata,
  input  wire logic        i_rvalid,
  output logic             o_rready = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;

  // Write; data lines go stale once taken so no old value lingers.
  // Response ready stays up afterwards: back-to-back writes never
  // drive it twice in one time step.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    o_awaddr  <= a;
    o_wdata   <= d;
    o_awvalid <= 1'b1;
    o_wvalid  <= 1'b1;
    o_bready  <= 1'b1;
    do begin
      @(posedge i_clk);
      if (i_awready) o_awvalid <= 1'b0;
      if (i_wready) o_wvalid <= 1'b0;
      if (i_wready) o_wdata <= ~d;
    end while (!i_bvalid);
  endtask

  // Read, data taken at the handshake edge
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    o_araddr  <= a;
    o_arvalid <= 1'b1;
    o_rready  <= 1'b1;
    do begin
      @(posedge i_clk);
      if (i_arready) o_arvalid <= 1'b0;
    end while (!i_rvalid);
    d = i_rdata;
    o_rready <= 1'b0;
  endtask

  // One command, one write per word
  task automatic send(input logic [15:0] w[$]);
    foreach (w[i]) wr(12'h000, {16'h0000, w[i]});
  endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Bench for the follow and velocity mode block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic [11:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, o_vel_cmd;
  logic [31:0] o_slave_delta, o_vel_ff, o_input_cmd;
  logic        o_tick;
  logic        i_enc_a = 1'b0;
  logic        i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid;
  logic        i_bready, i_arvalid, o_arready, o_rvalid, i_rready;
  logic [2:0]  o_mode;
  logic [3:0]  o_ext_style;
  int          error_cnt = 0;
  int          tests_run = 0;

  sfv_follow sfv_follow_i (
    .i_clk, .i_reset_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb(4'hf), .i_wvalid, .o_wready, .o_bresp(), .o_bvalid,
    .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp(),
    .o_rvalid, .i_rready, .i_enc_a, .i_enc_b(1'b0), .i_io(8'h00),
    .o_mode, .o_tick, .o_slave_delta, .o_vel_ff, .o_vel_cmd,
    .o_input_cmd, .o_ext_style, .o_index_src(), .o_index_state()
  );
  sfv_host sfv_host_i (
    .i_clk, .o_awaddr(i_awaddr), .o_awvalid(i_awvalid),
    .i_awready(o_awready), .o_wdata(i_wdata), .o_wvalid(i_wvalid),
    .i_wready(o_wready), .i_bvalid(o_bvalid), .o_bready(i_bready),
    .o_araddr(i_araddr), .o_arvalid(i_arvalid), .i_arready(o_arready),
    .i_rdata(o_rdata), .i_rvalid(o_rvalid), .o_rready(i_rready)
  );

  // 20 MHz clock
  initial forever #25 i_clk = ~i_clk;

  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask

  // Send a command, then judge the answer code and the mode
  task automatic do_cmd(input logic [15:0] w[$], input logic [7:0] r,
                        input logic [2:0] m);
    logic [31:0] d;
    sfv_host_i.send(w);
    sfv_host_i.rd(12'h004, d);
    chk("answer", {24'h0, r}, {24'h0, d[7:0]});
    chk("mode", {29'h0, m}, {29'h0, o_mode});
  endtask

  task automatic s_gear;
    do_cmd('{16'h00df, 16'h0009}, 8'h03, 3'h0);
    do_cmd('{16'h00df, 16'h00c7}, 8'h01, 3'h1);
    do_cmd('{16'h00df, 16'h00c8}, 8'h03, 3'h1);
    do_cmd('{16'h00c0, 16'h0, 16'h0, 16'h2}, 8'h01, 3'h1);
    chk("style", 32'h2, {28'h0, o_ext_style});
    do_cmd('{16'h00b4, 16'h8000}, 8'h03, 3'h1);
    do_cmd('{16'h00b4, 16'h8001}, 8'h01, 3'h2);
  endtask

  // Mode holds until the last word lands; matching stop input ends it
  task automatic s_inputs;
    sfv_host_i.wr(12'h430, 32'h8000);
    sfv_host_i.send('{16'h00da, 16'h7530, 16'h0001});
    chk("mode", 32'h2, {29'h0, o_mode});
    do_cmd('{16'h0000}, 8'h01, 3'h3);
    repeat (2400) @(posedge i_clk);
    chk("mode", 32'h0, {29'h0, o_mode});
    chk("input", 32'h0ad0, o_input_cmd);
    do_cmd('{16'h00d9, 16'h8000, 16'h0, 16'h0}, 8'h03, 3'h0);
    do_cmd('{16'h00d9, 16'h7fff, 16'h0, 16'h0}, 8'h01, 3'h4);
  endtask

  // Busy refusal, then takeover with multitasking, then stop by zero
  task automatic s_prog;
    logic [15:0] q[$];
    q = '{16'h009f, 16'h3fff, 16'hffff, 16'h0, 16'h0064, 16'h0, 16'h0};
    do_cmd(q, 8'h02, 3'h4);
    sfv_host_i.wr(12'h008, 32'h1);
    do_cmd(q, 8'h01, 3'h5);
    repeat (7200) @(posedge i_clk);
    chk("velocity", 32'h64, o_vel_cmd);
    q[4] = 16'h0000;
    do_cmd(q, 8'h01, 3'h5);
    repeat (7200) @(posedge i_clk);
    chk("mode", 32'h0, {29'h0, o_mode});
  endtask

  // Five step pulses geared at minus one; sums span three ticks
  task automatic s_follow;
    logic [31:0] sl, ff;
    sl = 32'h0;
    ff = 32'h0;
    do_cmd('{16'h00b4, 16'hfc00}, 8'h01, 3'h2);
    for (int c = 0; c < 7500; c++) begin
      @(posedge i_clk);
      if (c < 80) i_enc_a <= c[3];
      if (o_tick) begin
        sl = sl + o_slave_delta;
        ff = ff + o_vel_ff;
      end
    end
    chk("slave", 32'hfffffffb, sl);
    chk("feedforward", 32'h00050000, ff);
  endtask

  task automatic final_report;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Reset for six cycles, then the scenarios
  initial begin
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    s_gear();
    s_inputs();
    s_prog();
    s_follow();
    final_report();
  end

  // Watchdog well past the expected run length
  initial begin
    repeat (40000) @(posedge i_clk);
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
